// *** dv/vsc_frontend_tb.sv ***
// Self-checking bench of the serial command front end.
// Assumes the host model drives the link and Wishbone reads status.
`timescale 1ns/1ps
module vsc_frontend_tb;
   import vsc_pkg::*;
   logic clk;
   logic srst;
   logic frameStrobe, shiftClk, serialIn, serialOut, serialOutOe;
   logic [3:0] keyReturnLines;
   logic [3:0] switchInputs;
   logic [11:0] segmentKeysourceLines;
   logic [7:0] sharedSegmentGridLines, gridLines;
   logic [4:0] lampOutputs;
   logic wb_cyc_i, wb_stb_i, wb_we_i;
   logic [3:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   // Byte lanes used by writes
   logic [3:0] wrSel;
   logic [31:0] wb_dat_i;
   logic [31:0] wb_dat_o, q;
   logic wb_ack_o;
   logic [7:0] rx;
   int fails = 0;
   int tests_run = 0;

   // 100 MHz clock
   always #5 clk = ~clk;

   vsc_frontend #(.SLOT_CYC(4)) vsc_frontend_inst (.clk(clk), .srst(srst),
      .frameStrobe(frameStrobe), .shiftClk(shiftClk), .serialIn(serialIn),
      .serialOut(serialOut), .serialOutOe(serialOutOe),
      .keyReturnLines(keyReturnLines), .switchInputs(switchInputs),
      .segmentKeysourceLines(segmentKeysourceLines),
      .sharedSegmentGridLines(sharedSegmentGridLines),
      .gridLines(gridLines), .lampOutputs(lampOutputs),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

   vsc_host_model vsc_host_model_inst (.clk(clk), .serialOut(serialOut),
      .serialOutOe(serialOutOe), .frameStrobe(frameStrobe),
      .shiftClk(shiftClk), .serialIn(serialIn));

   // Verdict and end of run
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Compare seen against expected
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One classic Wishbone cycle, bounded wait for ack
   task automatic wb(input logic we, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_sel_i <= we ? wrSel : 4'hf;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 50);
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      if (n >= 50)
      begin
         fails++;
         final_report();
      end
   endtask

   // Expected status fields: mode, on, dim, address
   function automatic logic [31:0] st(input logic [3:0] m, input logic on,
                                      input logic [2:0] dm, input logic [5:0] a);
      return {10'h000, a, 5'h00, dm, 3'h0, on, m};
   endfunction

   // Read status, masking the data mode bits
   task automatic stat(input logic [31:0] e);
      wb(1'b0, REG_STATUS, 32'h0000_0000, q);
      check(q & 32'h003f_071f, e);
   endtask

   // Wait for a grid pattern, then check the segment lines
   task automatic scan_at(input logic [7:0] g, input logic [7:0] s,
                          input logic [11:0] e);
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while ((gridLines !== g || sharedSegmentGridLines !== s) && n < 200);
      if (n >= 200)
      begin
         fails++;
         final_report();
      end
      else
         check(segmentKeysourceLines, e);
   endtask

   // One strobe-low frame of n bytes, first byte lowest
   task automatic frame(input logic [23:0] b, input int n);
      vsc_host_model_inst.strobe(1'b0);
      for (int i = 0; i < n; i++)
         vsc_host_model_inst.shift(b[8*i+:8], 8, rx);
      vsc_host_model_inst.strobe(1'b1);
   endtask

   // Read frame: command, pause of 1.1 us, one byte back
   task automatic rd(input logic [7:0] c);
      vsc_host_model_inst.strobe(1'b0);
      vsc_host_model_inst.shift(c, 8, rx);
      vsc_host_model_inst.tick(110);
      vsc_host_model_inst.shift(8'hff, 8, rx);
      vsc_host_model_inst.strobe(1'b1);
   endtask

   // Main sequence
   initial
   begin
      clk = 1'b0;
      srst <= 1'b1;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      wb_adr_i <= 4'h0;
      wb_sel_i <= 4'hf;
      wb_dat_i <= 32'h0000_0000;
      wrSel <= 4'hf;
      keyReturnLines <= 4'h5;
      switchInputs <= 4'ha;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      stat(st(MODE_RESET, 1'b0, 3'h0, 6'h00));
      check(lampOutputs, 5'h1f);
      wb(1'b1, REG_CTRL, 32'h0000_0001, q);
      wb(1'b0, REG_CTRL, 32'h0000_0000, q);
      check(q, 32'h0000_0001);
      wb(1'b1, REG_CTRL, 32'h0000_0000, q);
      // Write without byte lane 0 leaves blanking off
      wrSel <= 4'he;
      wb(1'b1, REG_CTRL, 32'h0000_0001, q);
      wrSel <= 4'hf;
      wb(1'b0, REG_CTRL, 32'h0000_0000, q);
      check(q, 32'h0000_0000);
      wb(1'b0, 4'h2, 32'h0000_0000, q);
      check(q, 32'h0000_0000);
      // Aborted half byte of a display-on command
      vsc_host_model_inst.strobe(1'b0);
      vsc_host_model_inst.shift(8'h8f, 4, rx);
      vsc_host_model_inst.strobe(1'b1);
      stat(st(4'h8, 1'b0, 3'h0, 6'h00));
      // Clock edges with strobe high, then an address command
      vsc_host_model_inst.shift(8'h8f, 3, rx);
      frame(24'h0000c7, 1);
      stat(st(4'h8, 1'b0, 3'h0, 6'h07));
      // Second byte is data even if it looks like a command
      frame(24'h008fc3, 2);
      stat(st(4'h8, 1'b0, 3'h0, 6'h04));
      frame(24'h1122ee, 3);
      stat(st(4'h8, 1'b0, 3'h0, 6'h30));
      frame(24'h0055f0, 2);
      stat(st(4'h8, 1'b0, 3'h0, 6'h30));
      frame(24'h000074, 1);
      frame(24'h0201c5, 3);
      stat(st(4'h8, 1'b0, 3'h0, 6'h05));
      frame(24'h000040, 1);
      frame(24'h00008f, 1);
      stat(st(4'h8, 1'b1, 3'h7, 6'h05));
      frame(24'h000038, 1);
      stat(st(4'h8, 1'b1, 3'h7, 6'h05));
      // Digit two shows bytes 03h and low nibble of 04h
      scan_at(8'h02, 8'h00, 12'h08f);
      // Digit sixteen rides the first shared line as a grid
      scan_at(8'h00, 8'h01, 12'h200);
      // Let several display cycles latch the key returns
      vsc_host_model_inst.tick(400);
      wb(1'b0, REG_KEYLO, 32'h0000_0000, q);
      check(q, 32'h5555_5555);
      wb(1'b0, REG_KEYHI, 32'h0000_0000, q);
      check(q, 32'h0000_5555);
      rd(8'h42);
      check(rx, 8'h55);
      rd(8'h43);
      check(rx, 8'h0a);
      check(serialOutOe, 1'b0);
      // New key and switch levels reach the read paths
      keyReturnLines <= 4'hc;
      switchInputs <= 4'h6;
      vsc_host_model_inst.tick(400);
      wb(1'b0, REG_KEYLO, 32'h0000_0000, q);
      check(q, 32'hcccc_cccc);
      rd(8'h43);
      check(rx, 8'h06);
      frame(24'h000030, 1);
      stat(st(4'h0, 1'b0, 3'h7, 6'h05));
      vsc_host_model_inst.tick(200);
      check(gridLines, 8'h00);
      check(segmentKeysourceLines, 12'h000);
      // Every mode code, then an out-of-range one
      for (int m = 0; m < 9; m++)
      begin
         frame({20'h00000, 4'(m)}, 1);
         stat(st(4'(m), 1'b0, 3'h7, 6'h05));
      end
      frame(24'h000009, 1);
      stat(st(4'h8, 1'b0, 3'h7, 6'h05));
      final_report();
   end
endmodule

// *** dv/vsc_host_model.sv ***
// Host side of the strobe, shift clock and data link.
// Assumes the bench calls its tasks one at a time; data line pulled up.
`timescale 1ns/1ps
module vsc_host_model (
   input wire logic clk,
   input wire logic serialOut,
   input wire logic serialOutOe,
   output logic frameStrobe,
   output logic shiftClk,
   output logic serialIn
);
   // Data line level with its pull-up
   wire logic dataLine = serialOutOe ? serialOut : 1'b1;

   // Idle: strobe high, clock parked high
   initial
   begin
      frameStrobe = 1'b1;
      shiftClk = 1'b1;
      serialIn = 1'b1;
   end

   // Wait whole system clock cycles
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic strobe(input logic lvl);
      tick(1);
      frameStrobe <= lvl;
      tick(8);
   endtask

   // LSB first shifting, 80 ns clock
   task automatic shift(input logic [7:0] tx, input int n,
                        output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 0; i < n; i++)
      begin
         shiftClk <= 1'b0;
         serialIn <= tx[i];
         tick(4);
         // Line sampled just before the rise
         rx[i] = dataLine;
         shiftClk <= 1'b1;
         tick(3);
         // Data moves after the rise; a late sample sees the inverse
         serialIn <= ~tx[i];
         tick(1);
      end
   endtask
endmodule

// *** src/vsc_frontend.sv ***
// Serial command front end of a fluorescent display controller.
// Assumes pins arrive asynchronously and a Wishbone master for status.
`timescale 1ns/1ps
// Overview of operation
// - Sample data on shift clock rise, LSB first
// - Drive read data on falling edge, open drain
// - Strobe high ignores all shift clock edges
// - First byte after strobe falls is command
// - Early strobe rise discards partial byte
// - Mode command has b7,b6 zero; b5,b4 ignored
// - Nine grid and segment configurations
// - Mode change blanks display, stops scanning
// - Stay dark until display-on command
// - Same mode again changes nothing
// - Power-up mode is sixteen digits, twelve segments
// - Display data stored as bytes in RAM
// - Three bytes per digit, nibbles feed segments
// - Segment lines double as key sources
// - Key returns latched at display cycle end
// - Shared lines are segments or grids by mode
// - Address 30h or above discards data
// - Data command has b6 set, b7 clear
// - Power-up display off, narrowest pulse width
module vsc_frontend
   import vsc_pkg::*;
#(
   parameter int SLOT_CYC = DIGIT_SLOT_CYC
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic frameStrobe,
   input wire logic shiftClk,
   input wire logic serialIn,
   output logic serialOut,
   output logic serialOutOe,
   input wire logic [3:0] keyReturnLines,
   input wire logic [3:0] switchInputs,
   output logic [11:0] segmentKeysourceLines,
   output logic [7:0] sharedSegmentGridLines,
   output logic [7:0] gridLines,
   output logic [4:0] lampOutputs,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   // Synchronised pins
   logic [10:0] pinSync;
   logic stbS, sclkS, dinS;
   logic [3:0] keyS, swS;
   // Serial receive state
   logic sclkD_reg;
   logic [7:0] rxShift_reg;
   logic [2:0] bitCnt_reg;
   logic firstByte_reg;
   // Serial transmit state
   logic txActive_reg;
   logic [7:0] txShift_reg;
   logic [2:0] txBit_reg;
   logic [2:0] txIdx_reg;
   logic txSw_reg;
   // Settings held from commands
   logic [3:0] mode_reg;
   logic displayOn_reg;
   logic [2:0] dim_reg;
   logic [1:0] dataMode_reg;
   logic fixedAddr_reg;
   logic [5:0] addr_reg;
   // Display memory
   logic [7:0] ram [RAM_BYTES];
   // Scan state
   logic [31:0] slotCnt_reg;
   logic [4:0] pos_reg;
   logic [47:0] keyWork_reg;
   logic [47:0] keyRam_reg;
   // Software control
   logic blank_reg;

   // resync; strobe and clock inverted so reset reads idle high
   vsc_sync #(.WIDTH(11)) uSync (
      .clk(clk),
      .srst(srst),
      .din({switchInputs, keyReturnLines, serialIn, ~shiftClk, ~frameStrobe}),
      .dout(pinSync)
   );
   assign stbS = ~pinSync[0];
   assign sclkS = ~pinSync[1];
   assign dinS = pinSync[2];
   assign keyS = pinSync[6:3];
   assign swS = pinSync[10:7];

   // edges count only with strobe low
   wire riseEv = sclkS & ~sclkD_reg & ~stbS;
   wire fallEv = ~sclkS & sclkD_reg & ~stbS;
   // shift in from the top, LSB first
   wire [7:0] rxByte = {dinS, rxShift_reg[7:1]};
   wire byteDone = riseEv & (bitCnt_reg == BIT_LAST);
   wire isCmd = byteDone & firstByte_reg;
   // Bytes after the command; ignored while transmitting
   wire isData = byteDone & ~firstByte_reg & ~txActive_reg;
   wire [1:0] cmdType = rxByte[7:6];
   wire [3:0] modeCode = rxByte[3:0];
   wire modeWr = isCmd & (cmdType == CMD_MODE);
   // codes above the table are ignored
   wire modeNew = modeWr & (modeCode <= MODE_MAX) & (modeCode != mode_reg);
   wire dataWr = isCmd & (cmdType == CMD_DATA);
   wire ctrlWr = isCmd & (cmdType == CMD_CTRL);
   wire addrWr = isCmd & (cmdType == CMD_ADDR);
   wire readCmd = dataWr & rxByte[DM_READ_BIT];
   // writes only below the RAM limit
   wire addrOk = addr_reg < RAM_LIMIT;
   wire ramWr = isData & (dataMode_reg == DM_WR_DISP) & addrOk;
   wire lampWr = isData & (dataMode_reg == DM_WR_LAMP);
   // Transmit byte sources
   wire [7:0] swByte = {4'h0, swS};
   wire [7:0] keyNext = keyRam_reg[txIdx_reg*8 +: 8];
   wire [7:0] firstTx = rxByte[0] ? swByte : keyRam_reg[7:0];
   wire [2:0] idxWrap = (txIdx_reg == 3'(KEY_BYTES - 1)) ? 3'h0
                        : txIdx_reg + 3'h1;

   // Edge history of the shift clock
   always_ff @(posedge clk)
   begin
      if (srst)
         sclkD_reg <= 1'b1;
      else
         sclkD_reg <= sclkS;
   end

   // Receive shifter and byte framing
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rxShift_reg <= 8'h00;
         bitCnt_reg <= 3'h0;
         firstByte_reg <= 1'b1;
      end
      else if (stbS)
      begin
         bitCnt_reg <= 3'h0;
         firstByte_reg <= 1'b1;
      end
      // first full byte is the command
      else if (riseEv)
      begin
         rxShift_reg <= rxByte;
         bitCnt_reg <= bitCnt_reg + 3'h1;
         if (byteDone)
            firstByte_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         mode_reg <= MODE_RESET;
         displayOn_reg <= 1'b0;
         dim_reg <= DIM_RESET;
         dataMode_reg <= DM_WR_DISP;
         fixedAddr_reg <= 1'b0;
      end
      else
      begin
         if (modeNew)
         begin
            mode_reg <= modeCode;
            displayOn_reg <= 1'b0;
         end
         else if (ctrlWr)
         begin
            displayOn_reg <= rxByte[CTRL_ON_BIT];
            dim_reg <= rxByte[2:0];
         end
         if (dataWr)
         begin
            dataMode_reg <= rxByte[1:0];
            fixedAddr_reg <= rxByte[DM_FIXED_BIT];
         end
      end
   end

   // address pointer and display RAM write
   always_ff @(posedge clk)
   begin
      if (srst)
         addr_reg <= ADDR_RESET;
      else if (addrWr)
         addr_reg <= rxByte[5:0];
      else if (ramWr && !fixedAddr_reg)
         addr_reg <= addr_reg + 6'h01;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         for (int i = 0; i < RAM_BYTES; i++)
            ram[i] <= 8'h00;
      end
      else if (ramWr)
         ram[addr_reg] <= rxByte;
   end

   // Lamp port, low turns a lamp on
   always_ff @(posedge clk)
   begin
      if (srst)
         lampOutputs <= LAMP_RESET;
      else if (lampWr)
         lampOutputs <= rxByte[4:0];
   end

   // read data changes on falling edges
   always_ff @(posedge clk)
   begin
      if (srst || stbS)
      begin
         txActive_reg <= 1'b0;
         serialOutOe <= 1'b0;
         txShift_reg <= 8'h00;
         txBit_reg <= 3'h0;
         txIdx_reg <= 3'h0;
         txSw_reg <= 1'b0;
      end
      else if (readCmd)
      begin
         txActive_reg <= 1'b1;
         txShift_reg <= firstTx;
         txBit_reg <= 3'h0;
         txIdx_reg <= 3'h1;
         txSw_reg <= rxByte[0];
      end
      else if (fallEv && txActive_reg)
      begin
         // Open drain pulls low for a zero
         serialOutOe <= ~txShift_reg[0];
         txBit_reg <= txBit_reg + 3'h1;
         if (txBit_reg == BIT_LAST)
         begin
            // Key bytes follow in order, then wrap
            txShift_reg <= txSw_reg ? swByte : keyNext;
            txIdx_reg <= idxWrap;
         end
         else
            txShift_reg <= {1'b0, txShift_reg[7:1]};
      end
   end
   // Open drain only ever pulls low
   assign serialOut = 1'b0;

   // Scan geometry of the current mode
   wire [4:0] digits = BASE_DIGITS + {1'b0, mode_reg};
   wire [4:0] segCnt = MAX_SEGS - {1'b0, mode_reg};
   wire [4:0] lastPos = digits + KEY_SOURCES - 5'h01;
   wire inDisp = pos_reg < digits;
   wire [4:0] ksIdx = pos_reg - digits;
   wire slotEnd = slotCnt_reg == 32'(SLOT_CYC - 1);
   wire cycleEnd = slotEnd & (pos_reg == lastPos);
   wire scanOn = displayOn_reg;
   // three bytes per digit, nibble order
   wire [5:0] digBase = inDisp ? 6'(pos_reg * 5'h03) : 6'h00;
   wire [23:0] segBits = {ram[digBase + 6'h02], ram[digBase + 6'h01],
                          ram[digBase]};
   wire [15:0] gridHot = inDisp ? (16'h0001 << pos_reg) : 16'h0000;
   // key phase drives one source at a time
   wire [11:0] keySrc = inDisp ? 12'h000 : (12'h001 << ksIdx);
   wire [11:0] segNext = inDisp ? segBits[11:0] : keySrc;
   wire showOn = scanOn & ~blank_reg;
   logic [7:0] sharedNext;

   // shared line is segment or grid
   for (genvar j = 0; j < 8; j++)
   begin : gShared
      assign sharedNext[j] = (5'(j) < segCnt - KEY_SOURCES) ?
                             segBits[12 + j] : gridHot[15 - j];
   end

   // Slot timer and scan position
   always_ff @(posedge clk)
   begin
      if (srst || !scanOn)
      begin
         slotCnt_reg <= 32'h0000_0000;
         pos_reg <= 5'h00;
      end
      else if (slotEnd)
      begin
         slotCnt_reg <= 32'h0000_0000;
         pos_reg <= (pos_reg == lastPos) ? 5'h00 : pos_reg + 5'h01;
      end
      else
         slotCnt_reg <= slotCnt_reg + 32'h0000_0001;
   end

   // Registered driver outputs
   always_ff @(posedge clk)
   begin
      if (srst || !showOn)
      begin
         segmentKeysourceLines <= 12'h000;
         sharedSegmentGridLines <= 8'h00;
         gridLines <= 8'h00;
      end
      else
      begin
         segmentKeysourceLines <= segNext;
         sharedSegmentGridLines <= inDisp ? sharedNext : 8'h00;
         gridLines <= gridHot[7:0];
      end
   end

   // gather keys, publish at cycle end
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         keyWork_reg <= 48'h0000_0000_0000;
         keyRam_reg <= 48'h0000_0000_0000;
      end
      else if (scanOn && slotEnd)
      begin
         if (!inDisp)
            keyWork_reg[6'(ksIdx * 5'h04) +: 4] <= keyS;
         if (cycleEnd)
            keyRam_reg <= {keyS, keyWork_reg[43:0]};
      end
   end

   // Wishbone decode and answer in one cycle
   wire wbReq = wb_cyc_i & wb_stb_i;
   wire wbWrite = wbReq & wb_we_i & wb_ack_o;
   wire [31:0] statusWord = {4'h0, 2'(dataMode_reg), fixedAddr_reg,
                             1'b0, 2'h0, addr_reg, 5'h00, dim_reg,
                             3'h0, displayOn_reg, mode_reg};
   wire [31:0] rdMux = (wb_adr_i == REG_STATUS) ? statusWord :
                       (wb_adr_i == REG_CTRL) ? {31'h0, blank_reg} :
                       (wb_adr_i == REG_KEYLO) ? keyRam_reg[31:0] :
                       (wb_adr_i == REG_KEYHI) ? {16'h0000,
                                                  keyRam_reg[47:32]} :
                       32'h0000_0000;

   // Ack, read data and the control register
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         blank_reg <= 1'b0;
      end
      else
      begin
         wb_ack_o <= wbReq & ~wb_ack_o;
         wb_dat_o <= rdMux;
         if (wbWrite && wb_adr_i == REG_CTRL && wb_sel_i[0])
            blank_reg <= wb_dat_i[CTRL_BLANK_BIT];
      end
   end

   rx_lsb_a: assert property (@(posedge clk) disable iff (srst)
      riseEv |=> rxShift_reg[7] == $past(dinS))
      else $error("received bit not taken from data pin");
   tx_fall_a: assert property (@(posedge clk) disable iff (srst)
      fallEv && txActive_reg && !readCmd
      |=> serialOutOe == !$past(txShift_reg[0]))
      else $error("read bit not driven on falling edge");
   strobe_idle_a: assert property (@(posedge clk) disable iff (srst)
      stbS |=> bitCnt_reg == 3'h0 && !serialOutOe && !txActive_reg)
      else $error("activity while strobe high");
   cmd_first_a: assert property (@(posedge clk) disable iff (srst)
      isCmd && !stbS |=> !firstByte_reg)
      else $error("command byte not consumed");
   abort_frame_a: assert property (@(posedge clk) disable iff (srst)
      $rose(stbS) |=> firstByte_reg ##1 firstByte_reg)
      else $error("partial frame survived strobe rise");
   mode_off_a: assert property (@(posedge clk) disable iff (srst)
      modeNew |=> !displayOn_reg && mode_reg == $past(modeCode))
      else $error("mode change did not blank display");
   dark_hold_a: assert property (@(posedge clk) disable iff (srst)
      !displayOn_reg ##1 !displayOn_reg |-> gridLines == 8'h00)
      else $error("grids lit while display off");
   same_mode_a: assert property (@(posedge clk) disable iff (srst)
      modeWr && modeCode == mode_reg && !ctrlWr
      |=> displayOn_reg == $past(displayOn_reg))
      else $error("repeated mode disturbed display");
   reset_mode_a: assert property (@(posedge clk) disable iff (srst)
      $past(srst) |-> mode_reg == MODE_RESET && !displayOn_reg)
      else $error("wrong power-up mode");
   bad_addr_a: assert property (@(posedge clk) disable iff (srst)
      isData && !addrOk |=> addr_reg == $past(addr_reg))
      else $error("invalid address advanced");
   key_latch_a: assert property (@(posedge clk) disable iff (srst)
      $changed(keyRam_reg) |-> $past(cycleEnd))
      else $error("keys latched outside cycle end");
   data_cmd_a: assert property (@(posedge clk) disable iff (srst)
      dataWr |=> dataMode_reg == $past(rxByte[1:0]))
      else $error("data setting not stored");
endmodule

// *** src/vsc_pkg.sv ***
// Shared constants of the serial command front end.
// Assumes a 100 MHz system clock and a classic Wishbone register port.
package vsc_pkg;
   // System clock period
   localparam int CLK_NS = 10;
   // Time one digit or one key source is driven
   localparam int DIGIT_SLOT_NS = 5000;
   localparam int DIGIT_SLOT_CYC = DIGIT_SLOT_NS / CLK_NS;
   // Command classes in bits b7..b6
   localparam logic [1:0] CMD_MODE = 2'h0;
   localparam logic [1:0] CMD_DATA = 2'h1;
   localparam logic [1:0] CMD_CTRL = 2'h2;
   localparam logic [1:0] CMD_ADDR = 2'h3;
   // Data setting modes in bits b1..b0
   localparam logic [1:0] DM_WR_DISP = 2'h0;
   localparam logic [1:0] DM_WR_LAMP = 2'h1;
   localparam logic [1:0] DM_RD_KEY = 2'h2;
   localparam logic [1:0] DM_RD_SW = 2'h3;
   // Field positions inside command bytes
   localparam int DM_READ_BIT = 1;
   localparam int DM_FIXED_BIT = 2;
   localparam int CTRL_ON_BIT = 3;
   // Serial bit counter end
   localparam logic [2:0] BIT_LAST = 3'h7;
   // Mode code is digits minus eight; segments are twenty minus code
   localparam logic [3:0] MODE_MAX = 4'h8;
   localparam logic [3:0] MODE_RESET = 4'h8;
   localparam logic [4:0] BASE_DIGITS = 5'h08;
   localparam logic [4:0] MAX_SEGS = 5'h14;
   localparam logic [4:0] KEY_SOURCES = 5'h0c;
   localparam int KEY_BYTES = 6;
   localparam int RAM_BYTES = 48;
   // Display RAM limit and reset values
   localparam logic [5:0] RAM_LIMIT = 6'h30;
   localparam logic [5:0] ADDR_RESET = 6'h00;
   localparam logic [2:0] DIM_RESET = 3'h0;
   localparam logic [4:0] LAMP_RESET = 5'h1f;
   // Register byte offsets
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_CTRL = 4'h4;
   localparam logic [3:0] REG_KEYLO = 4'h8;
   localparam logic [3:0] REG_KEYHI = 4'hc;
   // Status and control field positions
   localparam int ST_ON_BIT = 4;
   localparam int ST_DIM_LSB = 8;
   localparam int ST_ADDR_LSB = 16;
   localparam int ST_DMODE_LSB = 24;
   localparam int CTRL_BLANK_BIT = 0;
endpackage

// *** src/vsc_sync.sv ***
// Two flip-flop synchroniser for a group of pin inputs.
// Assumes each bit is an independent level from outside the clock domain.
`timescale 1ns/1ps
module vsc_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   // First stage, read only by the second
   logic [WIDTH-1:0] meta_reg;

   // Two stages of resampling
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         meta_reg <= '0;
         dout <= '0;
      end
      else
      begin
         meta_reg <= din;
         dout <= meta_reg;
      end
   end
endmodule
